// ===== shared/lpm_map.vh
/*
 * Constants of the low-power mode controller: register offsets, field
 * positions, reset values, module bit layout and timing figures.
 * Assumes it is included by bare name from the controller source only.
 */
`ifndef LPM_MAP_VH
`define LPM_MAP_VH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LPM_CLK_PERIOD_NS       8
`define LPM_SETTLE_UNIT_NS      8192
`define LPM_SETTLE_UNIT_CYC     (`LPM_SETTLE_UNIT_NS / `LPM_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define LPM_ADDR_HW_STANDBY_PIN_CTRL      8'h00
`define LPM_ADDR_LP_CTRL        8'h01
`define LPM_ADDR_WDT_CSR        8'h02
`define LPM_ADDR_HALT_HI        8'h03
`define LPM_ADDR_HALT_LO        8'h04
`define LPM_ADDR_IRQ_EN         8'h05
`define LPM_ADDR_MODE_STAT      8'h06

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define LPM_HW_STANDBY_PIN_SEL_BIT        7
`define LPM_SETTLE_MSB          6
`define LPM_SETTLE_LSB          4
`define LPM_CLKDIV_MSB          2
`define LPM_CLKDIV_LSB          0
`define LPM_DIRECT_TRANSITION_ON_BIT_BIT            7
`define LPM_LOW_SPEED_ON_BIT_BIT            6
`define LPM_PSS_BIT             6

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LPM_HW_STANDBY_PIN_CTRL_RST       8'h00
`define LPM_LP_CTRL_RST         8'h00
`define LPM_WDT_CSR_RST         8'h00
`define LPM_IRQ_EN_RST          8'h00
`define LPM_HALT_RST            16'hFFFE
`define LPM_SYNC_RST            11'h600

// ----------------------------------------------------------------------
// Module halt bit layout
// ----------------------------------------------------------------------
`define LPM_MOD_TE              0
`define LPM_MOD_WDT1            4
`define LPM_MASK_LOWSPD_RUN     16'h001E
`define LPM_MASK_WATCH_RUN      16'h0010
`define LPM_MASK_NO_RETAIN      16'h03E0

`endif

// ===== rtl/low_power_mode_controller.v
/*
 * Low-power mode sequencer: high-speed, subactive, subsleep, watch,
 * hardware standby and reset states, per-module halt control and the
 * transfer-engine stop/bus-request conflict.
 * Assumes SLEEP_EXEC, CPU_IRQ_MASK, PERIPH_IRQ and TE_BUS_REQ come from
 * logic on MCLK; pins NMI_PIN, EXT_IRQ, RESET_PIN_N, HW_STANDBY_PIN_N
 * are asynchronous and are synchronised here.
 */
`timescale 1ns/10ps
`include "lpm_map.vh"

// Operation
// RULE_01: Sleep in subactive with standby 0, low-speed 1, prescaler 1 enters subsleep.
// RULE_02: Subsleep halts CPU and stops all modules but both timers and watchdogs.
// RULE_03: Subsleep wakes on peripheral, NMI, external lines, reset or standby pin.
// RULE_04: Accepted interrupt in subsleep goes to subactive and starts exception handling.
// RULE_05: Disabled external lines or masked or disabled peripheral interrupts never wake.
// RULE_06: Reset pin low starts oscillator and clock; reset handling begins at release.
// RULE_07: Outside source holds reset pin low until oscillator has settled.
// RULE_08: Standby pin low in subsleep or subactive forces hardware standby.
// RULE_09: Subsleep holds port values; CPU registers, some registers and RAM kept.
// RULE_10: Sleep in high-speed with standby 1, bits 11, prescaler 1 goes subactive.
// RULE_11: Interrupt in watch with low-speed bit 1 goes directly to subactive.
// RULE_12: Subactive runs CPU on subclock; modules but timers and watchdogs stopped.
// RULE_13: Software clears clock-divide field before running in subactive mode.
// RULE_14: Sleep in subactive with standby 1, direct 0, prescaler 1 enters watch.
// RULE_15: Sleep in subactive with standby 1, bits 01 goes high-speed after settling.
// RULE_16: Direct transitions keep executing; direct exception handling follows completion.
// RULE_17: Halt bit 1 stops module, 0 resumes it, at end of bus cycle.
// RULE_18: Stopped modules keep state except serial, converters and pulse-width units.
// RULE_19: After reset every module except transfer engine starts halted.
// RULE_20: Register access to a halted module has no effect.
// RULE_21: Stop request meeting transfer-engine bus request grants bus, bit stays clear.
// RULE_22: Mode held in state register; standby pin outranks every other condition.
module low_power_mode_controller
#(
   parameter integer SETTLE_UNIT_CYC = `LPM_SETTLE_UNIT_CYC,
   parameter integer NUM_PERIPH_IRQ  = 8
)
(
   input  wire                      MCLK,
   input  wire                      RESETN,
   input  wire [7:0]                REG_ADDR,
   input  wire [7:0]                REG_WDATA,
   input  wire                      REG_WR,
   input  wire                      REG_RD,
   output reg  [7:0]                REG_RDATA,
   input  wire                      SLEEP_EXEC,
   input  wire                      CPU_IRQ_MASK,
   input  wire [NUM_PERIPH_IRQ-1:0] PERIPH_IRQ,
   input  wire                      NMI_PIN,
   input  wire [7:0]                EXT_IRQ,
   input  wire                      RESET_PIN_N,
   input  wire                      HW_STANDBY_PIN_N,
   input  wire                      TE_BUS_REQ,
   output wire                      TE_BUS_GRANT,
   output reg  [6:0]                MODE_STATE,
   output reg                       CPU_HALT,
   output reg                       CPU_CLK_SUB,
   output reg                       SYS_CLK_ON,
   output reg                       OSC_START,
   output reg                       PORT_HOLD,
   output reg                       PORT_HIZ,
   output reg                       CORE_RESET,
   output reg  [15:0]               MODULE_STOP,
   output reg  [15:0]               MODULE_STATE_CLEAR,
   output reg  [15:0]               MODULE_ACCESS_EN,
   output reg                       RESET_EXC_START,
   output reg                       IRQ_EXC_START,
   output reg                       DIRECT_EXC_START
);

   // -------------------------------------------------------------------
   // States, one-hot
   // -------------------------------------------------------------------
   localparam [6:0] ST_HIGH   = 7'b000_0001;
   localparam [6:0] ST_SUBACT = 7'b000_0010;
   localparam [6:0] ST_SUBSLP = 7'b000_0100;
   localparam [6:0] ST_WATCH  = 7'b000_1000;
   localparam [6:0] ST_SETTLE = 7'b001_0000;
   localparam [6:0] ST_HWSTBY = 7'b010_0000;
   localparam [6:0] ST_RESET  = 7'b100_0000;

   // -------------------------------------------------------------------
   // Functions
   // -------------------------------------------------------------------
   // Settling delay in cycles; code 0 still waits one unit
   function [15:0] settle_cycles;
      input [2:0] code;
      reg   [31:0] prod;
      begin
         prod          = ({29'd0, code} + 32'd1) * SETTLE_UNIT_CYC;
         settle_cycles = prod[15:0];
      end
   endfunction

   // Modules forced off by a mode, whatever their halt bits say
   function [15:0] mode_stop_mask;
      input [6:0] st;
      begin
         case (st)
            ST_SUBACT, ST_SUBSLP : mode_stop_mask = ~`LPM_MASK_LOWSPD_RUN;
            ST_WATCH             : mode_stop_mask = ~`LPM_MASK_WATCH_RUN;
            ST_HWSTBY, ST_RESET  : mode_stop_mask = 16'hFFFF;
            default              : mode_stop_mask = 16'h0000;
         endcase
      end
   endfunction

   // -------------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------------
   reg  [10:0] sync1_q;
   reg  [10:0] sync2_q;
   reg  [7:0]  hw_standby_pin_ctrl_q;
   reg  [7:0]  hw_standby_pin_ctrl_d;
   reg  [7:0]  lp_ctrl_q;
   reg  [7:0]  lp_ctrl_d;
   reg  [7:0]  wdt_csr_q;
   reg  [7:0]  wdt_csr_d;
   reg  [7:0]  irq_en_q;
   reg  [7:0]  irq_en_d;
   reg  [15:0] halt_q;
   reg  [15:0] halt_d;
   reg  [6:0]  state_q;
   reg  [6:0]  state_d;
   reg  [15:0] settle_cnt_q;
   reg  [15:0] settle_cnt_d;
   reg         from_watch_q;
   reg         from_watch_d;
   reg         rst_exc_d;
   reg         irq_exc_d;
   reg         dir_exc_d;
   reg  [7:0]  rdata_d;
   reg  [15:0] stop_d;

   wire [7:0]  ext_irq_s;
   wire        nmi_s;
   wire        reset_pin_n_s;
   wire        hw_hw_standby_pin_n_s;
   wire        standby_select_bit;
   wire        low_speed_on_bit;
   wire        direct_transition_on_bit;
   wire        prescaler_select_bit;
   wire [2:0]  settle_time_field;
   wire        ext_wake;
   wire        periph_wake;
   wire        wake;
   wire        core_rst_now;
   wire        te_halt_req;

   // -------------------------------------------------------------------
   // Pin synchronisers
   // -------------------------------------------------------------------
   // Two stages; only the second stage feeds any logic
   always @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         sync1_q <= `LPM_SYNC_RST;
         sync2_q <= `LPM_SYNC_RST;
      end
      else
      begin
         sync1_q <= {HW_STANDBY_PIN_N, RESET_PIN_N, NMI_PIN, EXT_IRQ};
         sync2_q <= sync1_q;
      end
   end

   assign ext_irq_s     = sync2_q[7:0];
   assign nmi_s         = sync2_q[8];
   assign reset_pin_n_s = sync2_q[9];
   assign hw_hw_standby_pin_n_s   = sync2_q[10];

   // -------------------------------------------------------------------
   // Control fields
   // -------------------------------------------------------------------
   assign standby_select_bit       = hw_standby_pin_ctrl_q[`LPM_HW_STANDBY_PIN_SEL_BIT];
   assign settle_time_field        = hw_standby_pin_ctrl_q[`LPM_SETTLE_MSB:`LPM_SETTLE_LSB];
   assign low_speed_on_bit         = lp_ctrl_q[`LPM_LOW_SPEED_ON_BIT_BIT];
   assign direct_transition_on_bit = lp_ctrl_q[`LPM_DIRECT_TRANSITION_ON_BIT_BIT];
   assign prescaler_select_bit     = wdt_csr_q[`LPM_PSS_BIT];

   // -------------------------------------------------------------------
   // Wake qualification
   // -------------------------------------------------------------------
   // External lines need their enable and an unmasked CPU, peripheral requests only an unmasked CPU; NMI never masks
   assign ext_wake    = (|(ext_irq_s & irq_en_q)) & ~CPU_IRQ_MASK;   // see RULE_05
   assign periph_wake = (|PERIPH_IRQ) & ~CPU_IRQ_MASK; // see RULE_05
   assign wake        = nmi_s | ext_wake | periph_wake; // see RULE_03

   // Whole chip held in reset while in the reset or standby state
   assign core_rst_now = (state_q == ST_RESET) || (state_q == ST_HWSTBY);

   // Bus wins over a simultaneous stop request for the transfer engine
   assign te_halt_req  = REG_WR && (REG_ADDR == `LPM_ADDR_HALT_LO)
                         && REG_WDATA[`LPM_MOD_TE];
   assign TE_BUS_GRANT = TE_BUS_REQ & ~halt_q[`LPM_MOD_TE];         // see RULE_21

   // -------------------------------------------------------------------
   // Register file, next values
   // -------------------------------------------------------------------
   // Writes land at the cycle's closing edge, so halts act at bus-cycle end
   always @*
   begin
      hw_standby_pin_ctrl_d = hw_standby_pin_ctrl_q;
      lp_ctrl_d   = lp_ctrl_q;
      wdt_csr_d   = wdt_csr_q;
      irq_en_d    = irq_en_q;
      halt_d      = halt_q;
      if (core_rst_now)
      begin
         // Reset state reloads defaults, so release finds modules halted
         hw_standby_pin_ctrl_d = `LPM_HW_STANDBY_PIN_CTRL_RST;
         lp_ctrl_d   = `LPM_LP_CTRL_RST;
         wdt_csr_d   = `LPM_WDT_CSR_RST;
         irq_en_d    = `LPM_IRQ_EN_RST;
         halt_d      = `LPM_HALT_RST; // see RULE_19
      end
      else if (REG_WR)
      begin
         case (REG_ADDR)
            `LPM_ADDR_HW_STANDBY_PIN_CTRL : hw_standby_pin_ctrl_d = REG_WDATA;
            `LPM_ADDR_LP_CTRL   : lp_ctrl_d   = REG_WDATA & 8'hC0;
            `LPM_ADDR_WDT_CSR   : wdt_csr_d   = REG_WDATA & 8'h40;
            `LPM_ADDR_IRQ_EN    : irq_en_d    = REG_WDATA;
            `LPM_ADDR_HALT_HI   : halt_d[15:8] = REG_WDATA;          // see RULE_17
            `LPM_ADDR_HALT_LO   :
            begin
               halt_d[7:0] = REG_WDATA; // see RULE_17
               // A pending bus request keeps the engine running
               if (te_halt_req && TE_BUS_REQ)
                  halt_d[`LPM_MOD_TE] = 1'b0; // see RULE_21
            end
            default             : halt_d = halt_q;
         endcase
      end
   end

   // Read data one cycle after the strobe; unmapped reads give zero
   always @*
   begin
      rdata_d = 8'h00;
      if (REG_RD)
      begin
         case (REG_ADDR)
            `LPM_ADDR_HW_STANDBY_PIN_CTRL : rdata_d = hw_standby_pin_ctrl_q;
            `LPM_ADDR_LP_CTRL   : rdata_d = lp_ctrl_q;
            `LPM_ADDR_WDT_CSR   : rdata_d = wdt_csr_q;
            `LPM_ADDR_HALT_HI   : rdata_d = halt_q[15:8];
            `LPM_ADDR_HALT_LO   : rdata_d = halt_q[7:0];
            `LPM_ADDR_IRQ_EN    : rdata_d = irq_en_q;
            `LPM_ADDR_MODE_STAT : rdata_d = {1'b0, state_q};
            default             : rdata_d = 8'h00;
         endcase
      end
   end

   // -------------------------------------------------------------------
   // Mode sequencer
   // -------------------------------------------------------------------
   // Standby pin checked first, then reset pin, then per-state moves
   always @*
   begin
      state_d      = state_q;
      settle_cnt_d = settle_cnt_q;
      from_watch_d = from_watch_q;
      rst_exc_d    = 1'b0;
      irq_exc_d    = 1'b0;
      dir_exc_d    = 1'b0;
      if (!hw_hw_standby_pin_n_s)
         state_d = ST_HWSTBY; // see RULE_08, see RULE_22
      else if (!reset_pin_n_s)
         state_d = ST_RESET; // see RULE_06
      else
      begin
         case (state_q)
            ST_HIGH :
            begin
               if (SLEEP_EXEC && standby_select_bit && prescaler_select_bit)
               begin
                  if (low_speed_on_bit && direct_transition_on_bit)
                  begin
                     state_d   = ST_SUBACT; // see RULE_10
                     dir_exc_d = 1'b1; // see RULE_16
                  end
                  else if (!direct_transition_on_bit)
                     state_d = ST_WATCH;
               end
            end
            ST_SUBACT :
            begin
               if (SLEEP_EXEC && prescaler_select_bit)
               begin
                  if (!standby_select_bit && low_speed_on_bit)
                     state_d = ST_SUBSLP; // see RULE_01
                  else if (standby_select_bit && !direct_transition_on_bit)
                     state_d = ST_WATCH; // see RULE_14
                  else if (standby_select_bit && !low_speed_on_bit)
                  begin
                     // CPU keeps running on the subclock while settling
                     state_d      = ST_SETTLE; // see RULE_15
                     settle_cnt_d = settle_cycles(settle_time_field);
                     from_watch_d = 1'b0;
                  end
               end
            end
            ST_SUBSLP :
            begin
               if (wake)
               begin
                  state_d   = ST_SUBACT; // see RULE_04
                  irq_exc_d = 1'b1; // see RULE_04
               end
            end
            ST_WATCH :
            begin
               if (wake && low_speed_on_bit)
               begin
                  state_d   = ST_SUBACT; // see RULE_11
                  irq_exc_d = 1'b1;
               end
               else if (wake)
               begin
                  state_d      = ST_SETTLE;
                  settle_cnt_d = settle_cycles(settle_time_field);
                  from_watch_d = 1'b1;
               end
            end
            ST_SETTLE :
            begin
               if (settle_cnt_q == 16'h0000)
               begin
                  state_d   = ST_HIGH; // see RULE_15
                  // Exception kind depends on how the wait was entered
                  irq_exc_d = from_watch_q;
                  dir_exc_d = ~from_watch_q; // see RULE_16
               end
               else
                  settle_cnt_d = settle_cnt_q - 16'h0001;
            end
            ST_HWSTBY :
               state_d = ST_RESET;
            ST_RESET :
            begin
               // Oscillator settling is the reset source's job
               state_d   = ST_HIGH; // see RULE_07
               rst_exc_d = 1'b1; // see RULE_06
            end
            default :
               state_d = ST_RESET;
         endcase
      end
   end

   // Effective stop: halt bits plus whatever the coming mode forbids
   always @*
   begin
      stop_d = halt_d | mode_stop_mask(state_d);             // see RULE_02, see RULE_12
   end

   // -------------------------------------------------------------------
   // State and register flops
   // -------------------------------------------------------------------
   always @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         state_q      <= ST_HIGH;
         settle_cnt_q <= 16'h0000;
         from_watch_q <= 1'b0;
         hw_standby_pin_ctrl_q  <= `LPM_HW_STANDBY_PIN_CTRL_RST;
         lp_ctrl_q    <= `LPM_LP_CTRL_RST;
         wdt_csr_q    <= `LPM_WDT_CSR_RST;
         irq_en_q     <= `LPM_IRQ_EN_RST;
         halt_q       <= `LPM_HALT_RST; // see RULE_19
      end
      else
      begin
         state_q      <= state_d; // see RULE_22
         settle_cnt_q <= settle_cnt_d;
         from_watch_q <= from_watch_d;
         hw_standby_pin_ctrl_q  <= hw_standby_pin_ctrl_d;
         lp_ctrl_q    <= lp_ctrl_d;
         wdt_csr_q    <= wdt_csr_d;
         irq_en_q     <= irq_en_d;
         halt_q       <= halt_d;
      end
   end

   // -------------------------------------------------------------------
   // Registered outputs
   // -------------------------------------------------------------------
   // Built from next values so they track the state register exactly
   always @(posedge MCLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         REG_RDATA          <= 8'h00;
         MODE_STATE         <= ST_HIGH;
         CPU_HALT           <= 1'b0;
         CPU_CLK_SUB        <= 1'b0;
         SYS_CLK_ON         <= 1'b1;
         OSC_START          <= 1'b1;
         PORT_HOLD          <= 1'b0;
         PORT_HIZ           <= 1'b0;
         CORE_RESET         <= 1'b0;
         MODULE_STOP        <= `LPM_HALT_RST;
         MODULE_STATE_CLEAR <= `LPM_HALT_RST & `LPM_MASK_NO_RETAIN;
         MODULE_ACCESS_EN   <= ~`LPM_HALT_RST;
         RESET_EXC_START    <= 1'b0;
         IRQ_EXC_START      <= 1'b0;
         DIRECT_EXC_START   <= 1'b0;
      end
      else
      begin
         REG_RDATA          <= rdata_d;
         MODE_STATE         <= state_d;
         // Halted in subsleep, watch, reset, standby and a settle entered from watch; a direct move runs on
         CPU_HALT           <= (state_d == ST_SUBSLP) || (state_d == ST_WATCH)
                               || (state_d == ST_HWSTBY) || (state_d == ST_RESET)
                               || ((state_d == ST_SETTLE) && from_watch_d);  // see RULE_02
         CPU_CLK_SUB        <= (state_d == ST_SUBACT)
                               || ((state_d == ST_SETTLE) && !from_watch_d); // see RULE_12
         // Reset pin turns the main clock on once its synchronised level puts the sequencer in reset
         SYS_CLK_ON         <= (state_d == ST_HIGH) || (state_d == ST_RESET)
                               || (state_d == ST_SETTLE);             // see RULE_06
         OSC_START          <= (state_d == ST_HIGH) || (state_d == ST_RESET)
                               || (state_d == ST_SETTLE);             // see RULE_06
         PORT_HOLD          <= (state_d == ST_SUBSLP) || (state_d == ST_WATCH); // see RULE_09
         PORT_HIZ           <= (state_d == ST_HWSTBY);
         CORE_RESET         <= (state_d == ST_HWSTBY) || (state_d == ST_RESET);
         MODULE_STOP        <= stop_d; // see RULE_17
         // Units that cannot hold state are cleared while stopped
         MODULE_STATE_CLEAR <= stop_d & `LPM_MASK_NO_RETAIN;          // see RULE_18
         MODULE_ACCESS_EN   <= ~stop_d; // see RULE_20
         RESET_EXC_START    <= rst_exc_d;
         IRQ_EXC_START      <= irq_exc_d;
         DIRECT_EXC_START   <= dir_exc_d;
      end
   end

endmodule // low_power_mode_controller

// ===== bench/lpm_checker.sv
/* Concurrent checks on the power-mode controller ports.
   Assumes it is bound into the controller; one domain on MCLK. */
`timescale 1ns/10ps
module lpm_checker
(
   input wire        MCLK,
   input wire        RESETN,
   input wire        TE_BUS_REQ,
   input wire        TE_BUS_GRANT,
   input wire [15:0] MODULE_STOP,
   input wire [15:0] MODULE_ACCESS_EN,
   input wire [6:0]  MODE_STATE,
   input wire        CPU_HALT,
   input wire        PORT_HOLD,
   input wire        HW_STANDBY_PIN_N,
   input wire        SYS_CLK_ON,
   input wire        IRQ_EXC_START,
   input wire        RESET_EXC_START
);
   // One domain, so clock and reset stand here once
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESETN);
   property p_grant; TE_BUS_GRANT == (TE_BUS_REQ && !MODULE_STOP[0]); endproperty
   a_grant: assert property (p_grant) else $error("bus grant wrong");
   property p_access; MODULE_ACCESS_EN == ~MODULE_STOP; endproperty
   a_access: assert property (p_access) else $error("access gate wrong");
   property p_subsleep; MODE_STATE == 7'h04 |-> CPU_HALT && PORT_HOLD; endproperty
   a_subsleep: assert property (p_subsleep) else $error("subsleep outputs");
   property p_subact; MODE_STATE == 7'h02 |-> !CPU_HALT && &(MODULE_STOP | 16'h001E); endproperty
   a_subact: assert property (p_subact) else $error("subactive outputs");
   property p_hw_standby_pin; !HW_STANDBY_PIN_N [*3] |-> ##[0:2] MODE_STATE == 7'h20; endproperty
   a_hw_standby_pin: assert property (p_hw_standby_pin) else $error("standby not entered");
   property p_rstclk; MODE_STATE == 7'h40 |-> SYS_CLK_ON; endproperty
   a_rstclk: assert property (p_rstclk) else $error("clock off in reset");
   property p_wake; $past(MODE_STATE) == 7'h04 && MODE_STATE == 7'h02 |-> IRQ_EXC_START; endproperty
   a_wake: assert property (p_wake) else $error("wake without handler");
   property p_rexc; RESET_EXC_START |-> MODE_STATE == 7'h01 && $past(MODE_STATE) == 7'h40; endproperty
   a_rexc: assert property (p_rexc) else $error("reset handler misplaced");
endmodule // lpm_checker

bind low_power_mode_controller lpm_checker CHK (.MCLK, .RESETN, .TE_BUS_REQ, .TE_BUS_GRANT,
   .MODULE_STOP, .MODULE_ACCESS_EN, .MODE_STATE, .CPU_HALT, .PORT_HOLD, .HW_STANDBY_PIN_N,
   .SYS_CLK_ON, .IRQ_EXC_START, .RESET_EXC_START);

// ===== bench/lpm_reset_source.sv
/* Model of the outside reset source driving the reset pin.
   Assumes MCLK; start is a one-cycle request from the bench. */
`timescale 1ns/10ps
module lpm_reset_source
#(
   parameter integer STAB_CYC = 40
)
(
   input  wire  mclk,
   input  wire  start,
   output logic pin_n
);
   int cnt = 0;
   initial pin_n = 1'b1;
   // Pin stays low until the oscillator has had time to settle
   always @(posedge mclk)
   begin
      cnt   <= start ? STAB_CYC : (cnt != 0 ? cnt - 1 : 0);
      pin_n <= !start && cnt == 0;
   end
endmodule // lpm_reset_source

// ===== bench/tb_low_power_mode_controller.sv
/* Bench of the power-mode controller: halt tests, table of sleep cases, then hand tests.
   Assumes the reset source model and the bound checker. */
`timescale 1ns/10ps
module tb_low_power_mode_controller;
   logic        MCLK, RESETN, REG_WR, REG_RD, SLEEP_EXEC, CPU_IRQ_MASK, NMI_PIN, rst_go;
   logic        HW_STANDBY_PIN_N, TE_BUS_REQ, TE_BUS_GRANT, RESET_PIN_N, SYS_CLK_ON;
   logic        RESET_EXC_START, DIRECT_EXC_START;
   logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, PERIPH_IRQ, EXT_IRQ, d;
   logic [6:0]  MODE_STATE;
   logic [15:0] MODULE_STOP;
   int          n_mismatch = 0, checked = 0, n;
   // Rows: standby ctrl, low-power ctrl, watchdog csr, mode; divide field 0
   logic [30:0] rows [4] = '{{8'h80, 8'hC0, 8'h40, 7'h02}, {8'h80, 8'hC0, 8'h40, 7'h02},
                             {8'h80, 8'h40, 8'h40, 7'h08}, {8'h00, 8'h40, 8'h40, 7'h04}};
   low_power_mode_controller #(.SETTLE_UNIT_CYC(4)) DUT
   (
      .MCLK, .RESETN, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .SLEEP_EXEC,
      .CPU_IRQ_MASK, .PERIPH_IRQ, .NMI_PIN, .EXT_IRQ, .RESET_PIN_N, .HW_STANDBY_PIN_N,
      .TE_BUS_REQ, .TE_BUS_GRANT, .MODE_STATE, .CPU_HALT(), .CPU_CLK_SUB(), .SYS_CLK_ON,
      .OSC_START(), .PORT_HOLD(), .PORT_HIZ(), .CORE_RESET(), .MODULE_STOP,
      .MODULE_STATE_CLEAR(), .MODULE_ACCESS_EN(), .RESET_EXC_START, .IRQ_EXC_START(),
      .DIRECT_EXC_START
   );
   lpm_reset_source SRC (.mclk(MCLK), .start(rst_go), .pin_n(RESET_PIN_N));
   // Compare helpers; outputs are read at the falling edge, once settled
   task chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask
   task tick(int k); repeat (k) @(negedge MCLK); endtask
   task automatic wait_hi(ref logic s); for (n = 0; s !== 1'b1 && n < 80; n++) tick(1); endtask
   task wr(input logic [7:0] a, v);
      @(posedge MCLK) {REG_ADDR, REG_WDATA, REG_WR} <= {a, v, 1'b1};
      @(posedge MCLK) REG_WR <= 1'b0;
      tick(1);
   endtask
   task rd(input logic [7:0] a);
      @(posedge MCLK) {REG_ADDR, REG_RD} <= {a, 1'b1};
      @(posedge MCLK) REG_RD <= 1'b0;
      tick(1);
      d = REG_RDATA;
   endtask
   task sleep();
      @(posedge MCLK) SLEEP_EXEC <= 1'b1;
      @(posedge MCLK) SLEEP_EXEC <= 1'b0;
      tick(2);
   endtask
   task test_done();
      $display("checked %0d, n_mismatch %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Free-running clock; the watchdog cuts a hang far beyond the run length
   initial
   begin
      MCLK = 1'b0;
      forever #4 MCLK = ~MCLK;
   end
   initial
   begin
      #50000;
      n_mismatch++;
      test_done();
   end
   initial
   begin
      {RESETN, REG_WR, REG_RD, SLEEP_EXEC, CPU_IRQ_MASK, NMI_PIN, TE_BUS_REQ, rst_go} = '0;
      {REG_ADDR, REG_WDATA, PERIPH_IRQ, EXT_IRQ, HW_STANDBY_PIN_N} = {32'h0000_0000, 1'b1};
      repeat (10) @(posedge MCLK);
      RESETN <= 1'b1;
      tick(2);
      chk(MODULE_STOP, 16'hFFFE);
      rd(8'h3F);
      chk(d, 8'h00);
      // Halt bit writes, then a stop request losing to a bus request
      wr(8'h04, 8'h00);
      chk(MODULE_STOP, 16'hFF00);
      @(posedge MCLK) TE_BUS_REQ <= 1'b1;
      wr(8'h04, 8'h01);
      chk({MODULE_STOP[0], TE_BUS_GRANT}, 2'b01);
      @(posedge MCLK) TE_BUS_REQ <= 1'b0;
      wr(8'h04, 8'h01);
      chk(MODULE_STOP, 16'hFF01);
      $display("reset and halt tests done");
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h00, rows[i][30:23]);
         wr(8'h01, rows[i][22:15]);
         wr(8'h02, rows[i][14:7]);
         sleep();
         chk(MODE_STATE, rows[i][6:0]);
         if (rows[i][6:0] > 7'h02)
         begin
            @(posedge MCLK) PERIPH_IRQ <= 8'h01;
            tick(3);
            chk(MODE_STATE, 7'h02);
            @(posedge MCLK) PERIPH_IRQ <= 8'h00;
         end
         $display("row %0d done", i);
      end
      // Masked and disabled sources must not wake; the non-maskable one must
      @(posedge MCLK) {CPU_IRQ_MASK, PERIPH_IRQ, EXT_IRQ} <= {1'b1, 16'hFFFF};
      sleep();
      tick(6);
      chk(MODE_STATE, 7'h04);
      @(posedge MCLK) NMI_PIN <= 1'b1;
      tick(6);
      chk(MODE_STATE, 7'h02);
      @(posedge MCLK) {CPU_IRQ_MASK, PERIPH_IRQ, EXT_IRQ, NMI_PIN} <= '0;
      $display("wake source test done");
      // Reset pin in subactive mode, released after the settle span
      @(posedge MCLK) rst_go <= 1'b1;
      @(posedge MCLK) rst_go <= 1'b0;
      tick(5);
      chk({MODE_STATE, SYS_CLK_ON}, {7'h40, 1'b1});
      wait_hi(RESET_EXC_START);
      chk({MODE_STATE, MODULE_STOP}, {7'h01, 16'hFFFE});
      // Settle code 3 with unit 4 gives 16 cycles before high speed
      wr(8'h00, 8'hB0);
      wr(8'h01, 8'hC0);
      wr(8'h02, 8'h40);
      sleep();
      rd(8'h06);
      chk(d, 8'h02);
      wr(8'h01, 8'h80);
      sleep();
      chk(MODE_STATE, 7'h10);
      wait_hi(DIRECT_EXC_START);
      chk({MODE_STATE, n >= 13 && n <= 17}, {7'h01, 1'b1});
      // Standby pin overrides, then leaves through the reset state
      @(posedge MCLK) HW_STANDBY_PIN_N <= 1'b0;
      tick(6);
      chk(MODE_STATE, 7'h20);
      @(posedge MCLK) HW_STANDBY_PIN_N <= 1'b1;
      wait_hi(RESET_EXC_START);
      chk(MODE_STATE, 7'h01);
      $display("reset, settle and standby tests done");
      test_done();
   end
endmodule // tb_low_power_mode_controller
